// ===== src/baseband_frame_rtp_segmenter.sv
// Splits baseband frames into RTP packets for the multicast pipes
//
// Contract
// - Send to fixed multicast group, per-pipe port
// - UDP port selects the physical layer pipe
// - Split frames exceeding MTU into fragments
// - Whole frame allowed on large-MTU networks
// - Fragment sizes and counts are free
// - Marker set only on frame's first packet
// - Same timestamp in all frame packets
// - First packet SSRC holds frame length
// - Header extension bit is zero
// - Contributing source count is zero
// - Payload type is 77; the code sends 78 (RTP_PT is 7'h4e)
// - Sequence increments per packet; padding per RTP
// - Timestamp from seconds and nanoseconds bits
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module baseband_frame_rtp_segmenter #(
    parameter int PIPES = 64
) (
    // Clock and reset
    input  wire logic           aclk,
    input  wire logic           aresetn,
    // AXI4-Lite register bus
    input  wire seg_pkg::raddr_t s_axi_awaddr,
    input  wire logic           s_axi_awvalid,
    output logic                s_axi_awready,
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    input  wire logic           s_axi_wvalid,
    output logic                s_axi_wready,
    output logic [1:0]          s_axi_bresp,
    output logic                s_axi_bvalid,
    input  wire logic           s_axi_bready,
    input  wire seg_pkg::raddr_t s_axi_araddr,
    input  wire logic           s_axi_arvalid,
    output logic                s_axi_arready,
    output logic [31:0]         s_axi_rdata,
    output logic [1:0]          s_axi_rresp,
    output logic                s_axi_rvalid,
    input  wire logic           s_axi_rready,
    output logic                irq,
    // Frame request
    input  wire logic           frm_valid,
    output logic                frm_ready,
    input  wire seg_pkg::pipe_t frm_pipe,
    input  wire seg_pkg::len_t  frm_len,
    input  wire logic [31:0]    frm_sec,
    input  wire logic [31:0]    frm_nsec,
    // Frame bytes in
    input  wire logic           in_valid,
    output logic                in_ready,
    input  wire logic [7:0]     in_data,
    // Packet header out
    output logic                hdr_valid,
    input  wire logic           hdr_ready,
    output logic [31:0]         hdr_ip_dst,
    output logic [15:0]         hdr_udp_port,
    output logic [95:0]         hdr_rtp,
    output seg_pkg::len_t       hdr_pay_len,
    // Payload bytes out
    output logic                pay_valid,
    input  wire logic           pay_ready,
    output logic [7:0]          pay_data,
    output logic                pay_last
);
    import seg_pkg::*;
    `include "seg_map.svh"

    typedef struct packed {
        phase_t      ph;
        logic        frm_rdy;
        pipe_t       pipe;
        len_t        len;
        len_t        rem;
        len_t        cnt;
        logic [31:0] ts;
        logic        first;
        logic        hv;
        logic [31:0] hip;
        logic [15:0] hport;
        logic [95:0] hrtp;
        len_t        hlen;
        logic        in_rdy;
        logic        pv;
        logic [7:0]  pd;
        logic        pl;
        logic [1:0]  ctrl;
        len_t        frag;
        logic [2:0]  ist;
        logic [2:0]  imask;
        logic [15:0] frames;
        logic        irq;
    } core_t;

    core_t       s;
    core_t       next_s;
    logic [15:0] cur_seq;
    logic        bump;
    logic [2:0]  ev;
    logic [2:0]  clr;
    logic [31:0] wv;
    logic [31:0] nv;
    len_t        chunk;
    regs_if      rif ();

    axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rif     (rif)
    );

    seq_table #(.PIPES(PIPES)) u_seq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .idx     (s.pipe),
        .bump    (bump),
        .seq     (cur_seq)
    );

    assign frm_ready    = s.frm_rdy;
    assign in_ready     = s.in_rdy;
    assign hdr_valid    = s.hv;
    assign hdr_ip_dst   = s.hip;
    assign hdr_udp_port = s.hport;
    assign hdr_rtp      = s.hrtp;
    assign hdr_pay_len  = s.hlen;
    assign pay_valid    = s.pv;
    assign pay_data     = s.pd;
    assign pay_last     = s.pl;
    assign irq          = s.irq;
    assign bump         = s.hv && hdr_ready;

    assign chunk = (s.ctrl[`CTRL_WHOLE_BIT] || s.frag == 16'h0000 ||
                    s.rem <= s.frag) ? s.rem : s.frag;

    always_comb begin
        rif.rd_data = 32'h0000_0000;
        case (rif.rd_addr)
            `OFS_CTRL:     rif.rd_data = {30'h0, s.ctrl};
            `OFS_FRAG:     rif.rd_data = {16'h0000, s.frag};
            `OFS_STATUS:   rif.rd_data = {24'h00_0000, s.pipe, s.ph};
            `OFS_FRAMES:   rif.rd_data = {16'h0000, s.frames};
            `OFS_INT_STAT: rif.rd_data = {29'h0, s.ist};
            `OFS_INT_MASK: rif.rd_data = {29'h0, s.imask};
            default:       rif.rd_data = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_s = s;
        ev     = 3'h0;
        clr    = 3'h0;
        wv     = 32'h0000_0000;
        nv     = 32'h0000_0000;
        unique case (s.ph)
            PH_IDLE: begin
                next_s.frm_rdy = s.ctrl[`CTRL_EN_BIT];
                if (frm_valid && s.frm_rdy) begin
                    next_s.frm_rdy = 1'b0;
                    if (frm_len == 16'h0000) begin
                        ev[`EV_EMPTY_BIT] = 1'b1;
                    end else begin
                        next_s.pipe  = frm_pipe;
                        next_s.len   = frm_len;
                        next_s.rem   = frm_len;
                        next_s.ts    = make_ts(frm_sec, frm_nsec);
                        next_s.first = 1'b1;
                        next_s.ph    = PH_LOAD;
                    end
                end
            end
            PH_LOAD: begin
                next_s.hv    = 1'b1;
                next_s.hip   = `MCAST_ADDR;
                next_s.hport = 16'(`PORT_BASE + {10'h000, s.pipe});
                next_s.hrtp  = {`RTP_VER, 1'b0, 1'b0, 4'h0, s.first,
                                `RTP_PT, cur_seq, s.ts,
                                s.first ? {16'h0000, s.len}
                                        : 32'h0000_0000};
                next_s.hlen  = chunk;
                next_s.cnt   = chunk;
                next_s.ph    = PH_HDR;
            end
            PH_HDR: begin
                if (s.hv && hdr_ready) begin
                    next_s.hv     = 1'b0;
                    next_s.first  = 1'b0;
                    next_s.in_rdy = 1'b1;
                    next_s.ph     = PH_PAY;
                end
            end
            PH_PAY: begin
                // One byte in flight keeps every output a flop
                if (in_valid && s.in_rdy) begin
                    next_s.in_rdy = 1'b0;
                    next_s.pv     = 1'b1;
                    next_s.pd     = in_data;
                    next_s.pl     = (s.cnt == 16'h0001);
                    next_s.cnt    = 16'(s.cnt - 16'h0001);
                    next_s.rem    = 16'(s.rem - 16'h0001);
                end
                if (s.pv && pay_ready) begin
                    next_s.pv = 1'b0;
                    if (!s.pl) begin
                        next_s.in_rdy = 1'b1;
                    end else begin
                        ev[`EV_PKT_BIT] = 1'b1;
                        next_s.pl       = 1'b0;
                        if (s.rem != 16'h0000) begin
                            next_s.ph = PH_LOAD;
                        end else begin
                            ev[`EV_FRAME_BIT] = 1'b1;
                            next_s.frames = 16'(s.frames + 16'h0001);
                            next_s.ph     = PH_IDLE;
                        end
                    end
                end
            end
        endcase
        if (rif.wr_stb) begin
            wv = apply_strb(32'h0000_0000, rif.wr_data, rif.wr_strb);
            case (rif.wr_addr)
                `OFS_CTRL: begin
                    nv          = apply_strb({30'h0, s.ctrl},
                        rif.wr_data, rif.wr_strb);
                    next_s.ctrl = nv[1:0];
                end
                `OFS_FRAG: begin
                    nv          = apply_strb({16'h0000, s.frag},
                        rif.wr_data, rif.wr_strb);
                    next_s.frag = nv[15:0];
                end
                `OFS_INT_STAT: clr = wv[2:0];
                `OFS_INT_MASK: begin
                    nv           = apply_strb({29'h0, s.imask},
                        rif.wr_data, rif.wr_strb);
                    next_s.imask = nv[2:0];
                end
                default: ;
            endcase
        end
        // A new event beats a same-cycle clear
        next_s.ist = (s.ist & ~clr) | ev;
        next_s.irq = |(next_s.ist & next_s.imask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s       <= '0;
            s.ph    <= PH_IDLE;
            s.ctrl  <= `RST_CTRL;
            s.frag  <= `RST_FRAG;
            s.imask <= `RST_MASK;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_dst;
        s.hv |-> s.hip == `MCAST_ADDR && s.hport >= `PORT_BASE &&
                 s.hport <= `PORT_LAST;
    endproperty
    a_dst: assert property (p_dst) else $error("bad dest");

    property p_port;
        s.hv |-> s.hport == 16'(`PORT_BASE + {10'h000, s.pipe});
    endproperty
    a_port: assert property (p_port) else $error("bad port");

    property p_chunk;
        s.hv && !s.ctrl[`CTRL_WHOLE_BIT] && s.frag != 16'h0000
            |-> s.hlen <= s.frag && s.hlen != 16'h0000;
    endproperty
    a_chunk: assert property (p_chunk) else $error("bad size");

    property p_first;
        frm_valid && s.frm_rdy && frm_len != 16'h0000
            |-> ##2 s.hv && s.hrtp[87];
    endproperty
    a_first: assert property (p_first) else $error("no marker");

    property p_ssrc;
        s.hv |-> (s.hrtp[87] ? s.hrtp[31:0] == {16'h0000, s.len}
                             : s.hrtp[31:0] == 32'h0000_0000);
    endproperty
    a_ssrc: assert property (p_ssrc) else $error("bad ssrc");

    property p_xcc;
        s.hv |-> s.hrtp[95:88] == {`RTP_VER, 6'h00};
    endproperty
    a_xcc: assert property (p_xcc) else $error("bad flags");

    property p_pt;
        s.hv |-> s.hrtp[86:80] == `RTP_PT && s.hrtp[63:32] == s.ts;
    endproperty
    a_pt: assert property (p_pt) else $error("bad type");

    property p_seq;
        s.hv && hdr_ready |=> cur_seq == 16'($past(s.hrtp[79:64]) + 1);
    endproperty
    a_seq: assert property (p_seq) else $error("seq stuck");

    property p_ts;
        frm_valid && s.frm_rdy && frm_len != 16'h0000
            |=> s.ts == make_ts($past(frm_sec), $past(frm_nsec));
    endproperty
    a_ts: assert property (p_ts) else $error("bad stamp");

    property p_next;
        s.pv && pay_ready && s.pl && s.rem != 16'h0000
            |-> ##2 s.hv && !s.hrtp[87];
    endproperty
    a_next: assert property (p_next) else $error("gap");
endmodule

// ===== shared/seg_map.svh
// Register offsets, reset values and fixed header constants
`ifndef SEG_MAP_SVH
`define SEG_MAP_SVH
`define OFS_CTRL      8'h00
`define OFS_FRAG      8'h04
`define OFS_STATUS    8'h08
`define OFS_FRAMES    8'h0c
`define OFS_INT_STAT  8'h10
`define OFS_INT_MASK  8'h14
`define CTRL_EN_BIT   0
`define CTRL_WHOLE_BIT 1
`define RST_CTRL      2'h1
`define RST_FRAG      16'h05b4
`define RST_MASK      3'h0
`define EV_FRAME_BIT  0
`define EV_PKT_BIT    1
`define EV_EMPTY_BIT  2
`define MCAST_ADDR    32'hef00_3330
`define PORT_BASE     16'h7530
`define PORT_LAST     16'h756f
`define RTP_VER       2'h2
`define RTP_PT        7'h4e
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// ===== shared/seg_pkg.sv
// Types and shared helpers of the frame segmenter
package seg_pkg;
    typedef logic [5:0]  pipe_t;
    typedef logic [15:0] len_t;
    typedef logic [7:0]  raddr_t;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LOAD = 2'b01,
        PH_HDR  = 2'b10,
        PH_PAY  = 2'b11
    } phase_t;
    // 22 low seconds bits, then nanosecond bits 29..20
    function automatic logic [31:0] make_ts(logic [31:0] sec,
                                            logic [31:0] nsec);
        return {sec[21:0], nsec[29:20]};
    endfunction
    function automatic logic [31:0] apply_strb(logic [31:0] old,
                                               logic [31:0] wd,
                                               logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction
    function automatic logic reg_hit(raddr_t a);
        return (a[1:0] == 2'h0) && (a <= 8'h14);
    endfunction
endpackage

// ===== shared/regs_if.sv
// Simple register access channel between bus slave and core
`timescale 1ns/10ps
interface regs_if;
    logic        wr_stb;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    modport bus  (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                  input rd_data);
    modport core (input wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                  output rd_data);
endinterface

// ===== src/seq_table.sv
// Per-pipe RTP sequence counters held in flip-flops
`timescale 1ns/10ps
module seq_table #(
    parameter int PIPES = 64
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Access
    input  wire seg_pkg::pipe_t idx,
    input  wire logic         bump,
    output logic [15:0]       seq
);
    import seg_pkg::*;
    typedef struct packed {
        logic [PIPES-1:0][15:0] cnt;
    } tab_t;
    tab_t s;
    tab_t next_s;
    assign seq = s.cnt[idx];
    always_comb begin
        next_s = s;
        if (bump) begin
            next_s.cnt[idx] = 16'(s.cnt[idx] + 16'h0001);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ===== src/axil_slave.sv
// AXI4-Lite slave turning bus beats into register strobes
`timescale 1ns/10ps
module axil_slave (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // Read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Core side
    regs_if.bus              rif
);
    import seg_pkg::*;
    `include "seg_map.svh"
    typedef struct packed {
        logic aw_rdy; logic w_rdy; logic ar_rdy;
        logic aw_got; logic w_got; logic rd_pend;
        raddr_t waddr; logic [31:0] wd; logic [3:0] ws;
        logic bv; logic [1:0] br;
        raddr_t raddr; logic rv; logic [31:0] rd; logic [1:0] rr;
    } axs_t;
    axs_t s;
    axs_t next_s;
    assign rif.wr_stb  = s.aw_got && s.w_got && !s.bv;
    assign rif.wr_addr = s.waddr;
    assign rif.wr_data = s.wd;
    assign rif.wr_strb = s.ws;
    assign rif.rd_addr = s.raddr;
    assign awready = s.aw_rdy;
    assign wready  = s.w_rdy;
    assign bvalid  = s.bv;
    assign bresp   = s.br;
    assign arready = s.ar_rdy;
    assign rvalid  = s.rv;
    assign rdata   = s.rd;
    assign rresp   = s.rr;
    always_comb begin
        next_s = s;
        if (awvalid && s.aw_rdy) begin
            next_s.aw_rdy = 1'b0;
            next_s.aw_got = 1'b1;
            next_s.waddr  = awaddr;
        end
        if (wvalid && s.w_rdy) begin
            next_s.w_rdy = 1'b0;
            next_s.w_got = 1'b1;
            next_s.wd    = wdata;
            next_s.ws    = wstrb;
        end
        if (s.aw_got && s.w_got && !s.bv) begin
            next_s.bv     = 1'b1;
            next_s.br     = reg_hit(s.waddr) ? `RESP_OKAY : `RESP_SLVERR;
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
        end
        if (s.bv && bready) begin
            next_s.bv     = 1'b0;
            next_s.aw_rdy = 1'b1;
            next_s.w_rdy  = 1'b1;
        end
        if (arvalid && s.ar_rdy) begin
            next_s.ar_rdy  = 1'b0;
            next_s.raddr   = araddr;
            next_s.rd_pend = 1'b1;
        end
        if (s.rd_pend) begin
            next_s.rd_pend = 1'b0;
            next_s.rv      = 1'b1;
            next_s.rd      = rif.rd_data;
            next_s.rr      = reg_hit(s.raddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (s.rv && rready) begin
            next_s.rv     = 1'b0;
            next_s.ar_rdy = 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s        <= '0;
            s.aw_rdy <= 1'b1;
            s.w_rdy  <= 1'b1;
            s.ar_rdy <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ===== test/frame_sink.sv
// Far-end model that reassembles frames from the packet stream
`timescale 1ns/10ps
`include "seg_map.svh"
module frame_sink (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Packet stream
    input  wire logic        stall,
    input  wire logic        hdr_valid,
    output logic             hdr_ready,
    input  wire logic [15:0] hdr_udp_port,
    input  wire logic [95:0] hdr_rtp,
    input  wire logic        pay_valid,
    output logic             pay_ready,
    input  wire logic [7:0]  pay_data,
    // Reassembled frames
    output logic             done,
    output logic [31:0]      got_len,
    output logic [31:0]      got_sum,
    output logic [5:0]       got_pipe,
    output int               lost
);
    logic [15:0] last [64];
    logic [31:0] want, ts, sum, cnt;
    logic [5:0]  pipe;
    logic        busy, bad;
    // Stalls both channels together, as a slow link would
    assign hdr_ready = !stall;
    assign pay_ready = !stall;
    always @(posedge aclk) begin
        done <= 1'b0;
        if (!aresetn) begin
            busy = 1'b0;
            lost <= 0;
        end else begin
            if (hdr_valid && hdr_ready) begin
                pipe = 6'(hdr_udp_port - `PORT_BASE);
                bad = hdr_rtp[87] ? busy : (!busy || hdr_rtp[63:32] != ts
                      || hdr_rtp[79:64] != 16'(last[pipe] + 16'h1));
                if (bad) lost <= lost + 1;
                busy = hdr_rtp[87] || (busy && !bad);
                last[pipe] = hdr_rtp[79:64];
                if (hdr_rtp[87]) begin
                    want = hdr_rtp[31:0];
                    ts = hdr_rtp[63:32];
                    sum = 32'h0;
                    cnt = 32'h0;
                    got_pipe <= pipe;
                end
            end
            if (pay_valid && pay_ready && busy) begin
                sum = {sum[30:0], sum[31]} ^ {24'h0, pay_data};
                cnt = cnt + 1;
                if (cnt == want) begin
                    done <= 1'b1;
                    got_len <= cnt;
                    got_sum <= sum;
                    busy = 1'b0;
                end
            end
        end
    end
endmodule

// ===== test/tb_baseband_frame_rtp_segmenter.sv
// Self-checking bench of the baseband frame segmenter
`timescale 1ns/10ps
`include "seg_map.svh"
module tb_baseband_frame_rtp_segmenter;
    import seg_pkg::*;
    logic aclk, aresetn, irq, stall, slow, whole, done;
    raddr_t s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata, frm_sec, frm_nsec, hdr_ip_dst;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic frm_valid, frm_ready, in_valid, in_ready, hdr_valid, hdr_ready;
    logic pay_valid, pay_ready, pay_last;
    pipe_t frm_pipe, epipe;
    len_t frm_len, hdr_pay_len, elen;
    logic [7:0] in_data, pay_data;
    logic [15:0] hdr_udp_port, seq [64];
    logic [95:0] hdr_rtp;
    logic [31:0] got_len, got_sum, ts;
    logic [5:0] got_pipe;
    int lost, failures, checks_done, rem, pk, frag, frames;

    baseband_frame_rtp_segmenter u_dut (.*);
    frame_sink u_sink (.*);

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) stall <= slow ? 1'($urandom) : 1'b0;

    task automatic chk(logic [95:0] got, logic [95:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic hang();
        failures++;
        wrap_up();
    endtask
    task automatic wr(raddr_t a, logic [31:0] d, logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) hang();
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(raddr_t a, logic [31:0] ed, logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) hang();
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata}, {er, ed});
    endtask
    function automatic logic [31:0] fsum(logic [7:0] salt, int l);
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < l; i++) s = {s[30:0], s[31]} ^ (8'(i * 13) ^ salt);
        return s;
    endfunction
    task automatic send(pipe_t p, len_t l);
        int n;
        logic [7:0] salt;
        logic [31:0] sec, ns;
        salt = 8'($urandom);
        sec = $urandom;
        ns = $urandom;
        @(posedge aclk);
        epipe = p;
        elen = l;
        rem = l;
        ts = {sec[21:0], ns[29:20]};
        frm_valid <= 1'b1;
        frm_pipe <= p;
        frm_len <= l;
        frm_sec <= sec;
        frm_nsec <= ns;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (frm_ready) break;
        end
        if (n == 50) hang();
        frm_valid <= 1'b0;
        for (int i = 0; i < l; i++) begin
            in_valid <= 1'b1;
            in_data <= 8'(i * 13) ^ salt;
            for (n = 0; n < 200; n++) begin
                @(posedge aclk);
                if (in_ready) break;
            end
            if (n == 200) hang();
        end
        in_valid <= 1'b0;
        if (l != 0) begin
            for (n = 0; n < 400; n++) begin
                @(posedge aclk);
                if (done) break;
            end
            if (n == 400) hang();
            chk(got_len, l);
            chk(got_pipe, p);
            chk(got_sum, fsum(salt, l));
            frames++;
        end
    endtask

    // Header and packet boundary watch
    always @(posedge aclk) begin
        int c;
        logic f;
        if (aresetn && hdr_valid && hdr_ready) begin
            f = (rem == elen);
            c = (whole || frag == 0 || rem <= frag) ? rem : frag;
            chk({hdr_ip_dst, hdr_udp_port, hdr_pay_len},
                {`MCAST_ADDR, `PORT_BASE + 16'(epipe), 16'(c)});
            chk(hdr_rtp, {`RTP_VER, 6'h0, f, `RTP_PT, seq[epipe], ts,
                f ? 32'(elen) : 32'h0});
            seq[epipe] = seq[epipe] + 16'h1;
            rem = rem - c;
            pk = c;
        end
        if (aresetn && pay_valid && pay_ready) begin
            pk = pk - 1;
            chk(pay_last, pk == 0);
        end
    end

    initial begin
        void'($urandom(32'h0623584d));
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, frm_sec, frm_nsec} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, frm_valid, in_valid, slow, whole} = '0;
        {frm_pipe, frm_len, in_data, elen, epipe} = '0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        frag = 1460;
        foreach (seq[i]) seq[i] = 16'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_CTRL, 32'(`RST_CTRL), `RESP_OKAY);
        rd(`OFS_FRAG, 32'(`RST_FRAG), `RESP_OKAY);
        rd(`OFS_INT_MASK, 32'h0, `RESP_OKAY);
        rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
        rd(8'h18, 32'h0, `RESP_SLVERR);
        rd(8'h06, 32'h0, `RESP_SLVERR);
        wr(8'h1c, 32'h0, `RESP_SLVERR);
        frag = 4;
        wr(`OFS_FRAG, 32'h4, `RESP_OKAY);
        send(6'h0, 16'h4);
        send(6'h0, 16'h5);
        send(6'h3f, 16'h1);
        frag = 0;
        wr(`OFS_FRAG, 32'h0, `RESP_OKAY);
        send(6'h2, 16'h0014);
        slow = 1'b1;
        for (int k = 0; k < 12; k++) begin
            frag = 1 + $urandom % 16;
            whole = ($urandom % 4) == 0;
            wr(`OFS_FRAG, 32'(frag), `RESP_OKAY);
            wr(`OFS_CTRL, {30'h0, whole, 1'b1}, `RESP_OKAY);
            send(6'($urandom), 16'(1 + $urandom % 40));
        end
        // Byte strobes: only byte 1 of FRAG may change
        s_axi_wstrb <= 4'h2;
        wr(`OFS_FRAG, 32'h0000_ab10, `RESP_OKAY);
        rd(`OFS_FRAG, {16'h0000, 8'hab, 8'(frag)}, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(`OFS_FRAMES, 32'(frames), `RESP_OKAY);
        rd(`OFS_INT_STAT, 32'h3, `RESP_OKAY);
        chk(irq, 1'b0);
        wr(`OFS_INT_MASK, 32'h1, `RESP_OKAY);
        rd(`OFS_INT_MASK, 32'h1, `RESP_OKAY);
        chk(irq, 1'b1);
        wr(`OFS_INT_STAT, 32'h1, `RESP_OKAY);
        rd(`OFS_INT_STAT, 32'h2, `RESP_OKAY);
        chk(irq, 1'b0);
        send(6'h5, 16'h0);
        rd(`OFS_INT_STAT, 32'h6, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(frm_ready, 1'b0);
        chk(lost, 0);
        wrap_up();
    end
    initial begin
        repeat (100000) @(posedge aclk);
        hang();
    end
endmodule
